// >>> sur_pkg.sv
// Package of offsets, fields, codes and reset values for the register map
`default_nettype none
package sur_pkg;
  // Slot addresses inside an upstream read block
  localparam logic [3:0] SLOT_0     = 4'h0;
  localparam logic [3:0] SLOT_4     = 4'h4;
  localparam logic [3:0] SLOT_8     = 4'h8;
  localparam logic [3:0] SLOT_C     = 4'hc;
  localparam logic [3:0] SLOT_1     = 4'h1;
  localparam logic [3:0] SLOT_5     = 4'h5;
  localparam logic [3:0] SLOT_9     = 4'h9;
  localparam logic [3:0] SLOT_D     = 4'hd;
  localparam logic [3:0] SLOT_2     = 4'h2;
  localparam logic [3:0] SLOT_6     = 4'h6;
  localparam logic [3:0] SLOT_A     = 4'ha;
  localparam logic [3:0] SLOT_E     = 4'he;
  localparam logic [3:0] SLOT_3     = 4'h3;
  localparam logic [3:0] SLOT_7     = 4'h7;
  localparam logic [3:0] SLOT_B     = 4'hb;
  localparam logic [3:0] SLOT_F     = 4'hf;
  // Downstream command codes
  localparam logic [7:0] CMD_WR_BASE  = 8'h00;
  localparam logic [7:0] CMD_RD_BASE  = 8'h10;
  localparam logic [7:0] CMD_RD_ONE   = 8'h20;
  localparam logic [7:0] CMD_LOCK     = 8'h30;
  localparam logic [7:0] CMD_UNLOCK   = 8'h31;
  // Reset values of the configuration words
  localparam logic [7:0] CFG1_RST   = 8'h08;
  localparam logic [7:0] CFG2_RST   = 8'h08;
  localparam logic [7:0] CFG3_RST   = 8'h08;
  localparam logic [7:0] CFG4_RST   = 8'h02;
  localparam logic [7:0] CFG5_RST   = 8'hd8;
  localparam logic [7:0] CFG6_RST   = 8'h22;
  localparam logic [7:0] CFG7_RST   = 8'h00;
  // Field positions
  localparam int THR_MSB   = 7;
  localparam int THR_LSB   = 5;
  localparam int FLT_MSB   = 4;
  localparam int FLT_LSB   = 2;
  localparam int MODE_BIT  = 1;
  localparam int CTRL_BIT  = 0;
  localparam int LOCK_BIT  = 0;
  localparam int CNT_W     = 5;
  // Frame lengths in bits
  localparam int DN_BITS   = 16;
  localparam int UP_BITS   = 64;
endpackage : sur_pkg
`default_nettype wire

// >>> sur_regmap.sv
// Upstream register map of the serial link with configuration words
`default_nettype none
// Operation
// - Eight read blocks, four 16-bit slots each
// - Config words 1-4 in block one
// - Block two: config 5-7, slot C zero
// - Diag words 1-4 in block three, read-only
// - Diag words 5-8 in block four, read-only
// - Block five: diag 9-11 and identity
// - Block six: query, zero, step high, low
// - Block seven: diag 12 twice, reply, time
// - Block seven slot 8 is watchdog reply
// - Block eight: time, request bytes, fail count
// - Output control words come in data frames
// - Step count split 5+5 bits, bit5 reserved
// - Bits 7:6 carry matching alignment markers
// - Identity: chip id, metal rev, mask rev
// - Config1 [7:5] predriver one threshold
// - Config1 [4:2] predriver one filter time
// - Config1 [1] flywheel interface adaptive mode
// - Config1 [0] relay overtemp keep on
// - Config2 [7:5] predriver two threshold
// - Config2 [4:2] predriver two filter time
// - Config2 [0] ignition lowside off, [1] pump
// - Single read returns 16-bit addressed frame
// - Lock flag blocks all config writes
module sur_regmap #(
  parameter logic [2:0] CHIP_ID   = 3'h7, // Arbitrary value
  parameter logic [2:0] METAL_REV = 3'h7, // Arbitrary value
  parameter logic [1:0] MASK_REV  = 2'h3  // Arbitrary value
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       link_clk,
  input  wire logic       link_en,
  input  wire logic       link_sdi,
  output logic            link_sdo,
  input  wire logic [7:0] diag_word [1:12],
  input  wire logic [7:0] watchdog_query,
  input  wire logic [7:0] watchdog_reply,
  input  wire logic [7:0] watchdog_reply_time,
  input  wire logic [7:0] watchdog_request_low,
  input  wire logic [7:0] watchdog_request_high,
  input  wire logic [7:0] watchdog_fail_counter,
  input  wire logic [9:0] step_total,
  input  wire logic       charge_pump_off,
  output logic [2:0]      pd1_short_thresh_sel,
  output logic [2:0]      pd1_short_filter_sel,
  output logic [2:0]      pd2_short_thresh_sel,
  output logic [2:0]      pd2_short_filter_sel,
  output logic            flywheel_full_adaptive,
  output logic            relay_overtemp_keep_on,
  output logic            ignition_lowside_force_off,
  output logic [7:0]      config_word_3,
  output logic [7:0]      config_word_4,
  output logic [7:0]      config_word_5,
  output logic [7:0]      config_word_6,
  output logic [7:0]      config_word_7
);
  import sur_pkg::*;

  logic [2:0]  clk_s_q;
  logic [2:0]  en_s_q;
  logic [2:0]  dat_s_q;
  logic        clk_f_q;
  logic        en_f_q;
  logic        clk_rise;
  logic        en_fall;
  logic [15:0] dn_q;
  logic [4:0]  bit_cnt_q;
  logic [63:0] up_q;
  logic [7:0]  cfg_q [1:7];
  logic [1:0]  mark_q;
  logic        exec;
  logic [7:0]  cmd;
  logic [7:0]  arg;

  // Three-stage sampling of the link pins
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clk_s_q <= 3'h0;
      en_s_q  <= 3'h0;
      dat_s_q <= 3'h0;
    end
    else
    begin
      clk_s_q <= {clk_s_q[1:0], link_clk};
      en_s_q  <= {en_s_q[1:0], link_en};
      dat_s_q <= {dat_s_q[1:0], link_sdi};
    end
  end

  // Levels change only when stages two and three agree
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clk_f_q <= 1'b0;
      en_f_q  <= 1'b0;
    end
    else
    begin
      if (clk_s_q[1] == clk_s_q[2])
        clk_f_q <= clk_s_q[2];
      if (en_s_q[1] == en_s_q[2])
        en_f_q <= en_s_q[2];
    end
  end

  assign clk_rise = (clk_s_q[1] == clk_s_q[2]) && clk_s_q[2] && !clk_f_q
                    && en_f_q;
  assign en_fall  = (en_s_q[1] == en_s_q[2]) && !en_s_q[2] && en_f_q;

  // Downstream shift and bit count
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dn_q      <= 16'h0000;
      bit_cnt_q <= 5'h00;
    end
    else if (!en_f_q)
      bit_cnt_q <= 5'h00;
    else if (clk_rise)
    begin
      dn_q <= {dn_q[14:0], dat_s_q[2]};
      if (bit_cnt_q != 5'(DN_BITS))
        bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  assign exec = en_fall && (bit_cnt_q == 5'(DN_BITS));
  // Control words of data frames are not decoded here
  assign cmd  = dn_q[15:8];
  assign arg  = dn_q[7:0];

  // Address of slot k inside block b
  function automatic logic [3:0] slot_addr(input logic [2:0] blk,
                                           input logic [1:0] k);
    logic [1:0] low;
    low = 2'h0;
    unique case (blk)
      3'd2:    low = 2'h1;
      3'd3:    low = 2'h2;
      3'd4:    low = 2'h3;
      3'd7:    low = 2'h1;
      default: low = 2'h0;
    endcase
    return {k, low};
  endfunction : slot_addr

  // Content of one slot; block is zero based
  function automatic logic [7:0] slot_data(input logic [2:0] blk,
                                           input logic [3:0] adr,
                                           input logic [7:0] cfg [1:7],
                                           input logic [7:0] dia [1:12],
                                           input logic [7:0] sh,
                                           input logic [7:0] sl,
                                           input logic [7:0] wq,
                                           input logic [7:0] wr,
                                           input logic [7:0] wt,
                                           input logic [7:0] wl,
                                           input logic [7:0] wh,
                                           input logic [7:0] wf,
                                           input logic [7:0] idw);
    logic [7:0] d;
    d = 8'h00;
    unique case ({blk, adr})
      {3'd0, SLOT_0}: d = cfg[1];
      {3'd0, SLOT_4}: d = cfg[2];
      {3'd0, SLOT_8}: d = cfg[3];
      {3'd0, SLOT_C}: d = cfg[4];
      {3'd1, SLOT_0}: d = cfg[5];
      {3'd1, SLOT_4}: d = cfg[6];
      {3'd1, SLOT_8}: d = cfg[7];
      {3'd2, SLOT_1}: d = dia[1];
      {3'd2, SLOT_5}: d = dia[2];
      {3'd2, SLOT_9}: d = dia[3];
      {3'd2, SLOT_D}: d = dia[4];
      {3'd3, SLOT_2}: d = dia[5];
      {3'd3, SLOT_6}: d = dia[6];
      {3'd3, SLOT_A}: d = dia[7];
      {3'd3, SLOT_E}: d = dia[8];
      {3'd4, SLOT_3}: d = dia[9];
      {3'd4, SLOT_7}: d = dia[10];
      {3'd4, SLOT_B}: d = dia[11];
      {3'd4, SLOT_F}: d = idw;
      {3'd5, SLOT_0}: d = wq;
      {3'd5, SLOT_8}: d = sh;
      {3'd5, SLOT_C}: d = sl;
      {3'd6, SLOT_0}: d = dia[12];
      {3'd6, SLOT_4}: d = dia[12];
      {3'd6, SLOT_8}: d = wr;
      {3'd6, SLOT_C}: d = wt;
      {3'd7, SLOT_1}: d = wt;
      {3'd7, SLOT_5}: d = wl;
      {3'd7, SLOT_9}: d = wh;
      {3'd7, SLOT_D}: d = wf;
      default:        d = 8'h00;
    endcase
    return d;
  endfunction : slot_data

  // Step count halves share one sample and one marker value
  logic [7:0] step_hi;
  logic [7:0] step_lo;
  logic [7:0] ident;
  logic [7:0] cfg_rd [1:7];
  assign step_hi = {mark_q, 1'b0, step_total[9:5]};
  assign step_lo = {mark_q, 1'b0, step_total[4:0]};
  assign ident   = {CHIP_ID, METAL_REV, MASK_REV};

  // Read view of the configuration words
  always_comb
  begin
    for (int i = 1; i <= 7; i++)
      cfg_rd[i] = cfg_q[i];
    cfg_rd[2][MODE_BIT] = charge_pump_off;
  end

  // Upstream frames: address, data, four zero bits
  logic [63:0] blk_frames;
  logic [15:0] one_frame;
  logic [2:0]  rd_blk;
  assign rd_blk = (cmd == CMD_RD_ONE) ? arg[6:4] : 3'(cmd[2:0] - 3'd1);

  always_comb
  begin
    logic [3:0] a;
    a = 4'h0;
    for (int k = 0; k < 4; k++)
    begin
      a = slot_addr(rd_blk, 2'(k));
      blk_frames[63 - 16 * k -: 16] =
        {a, slot_data(rd_blk, a, cfg_rd, diag_word, step_hi, step_lo,
                      watchdog_query, watchdog_reply, watchdog_reply_time,
                      watchdog_request_low, watchdog_request_high,
                      watchdog_fail_counter, ident), 4'h0};
    end
    one_frame = {arg[3:0],
                 slot_data(rd_blk, arg[3:0], cfg_rd, diag_word, step_hi,
                           step_lo, watchdog_query, watchdog_reply,
                           watchdog_reply_time, watchdog_request_low,
                           watchdog_request_high, watchdog_fail_counter,
                           ident), 4'h0};
  end

  logic is_rd_blk;
  assign is_rd_blk = (cmd[7:4] == CMD_RD_BASE[7:4]) && (cmd[3:0] >= 4'h1)
                     && (cmd[3:0] <= 4'h8);

  // Upstream shifter, one bit per link clock rise in a frame
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      up_q <= 64'h0000_0000_0000_0000;
    else if (exec && is_rd_blk)
      up_q <= blk_frames;
    else if (exec && cmd == CMD_RD_ONE)
      up_q <= {one_frame, 48'h0000_0000_0000};
    else if (clk_rise)
      up_q <= {up_q[62:0], 1'b0};
  end

  assign link_sdo = up_q[63];

  // Marker advances after each sample of the step count
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      mark_q <= 2'h0;
    else if (exec && ((is_rd_blk && rd_blk == 3'd5)
                      || (cmd == CMD_RD_ONE && rd_blk == 3'd5)))
      mark_q <= mark_q + 2'h1;
  end

  // Configuration writes, lock and unlock
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_q[1] <= CFG1_RST;
      cfg_q[2] <= CFG2_RST;
      cfg_q[3] <= CFG3_RST;
      cfg_q[4] <= CFG4_RST;
      cfg_q[5] <= CFG5_RST;
      cfg_q[6] <= CFG6_RST;
      cfg_q[7] <= CFG7_RST;
    end
    else if (exec)
    begin
      if (cmd == CMD_LOCK)
        cfg_q[4][LOCK_BIT] <= 1'b1;
      else if (cmd == CMD_UNLOCK)
        cfg_q[4][LOCK_BIT] <= 1'b0;
      else if (cmd[7:3] == CMD_WR_BASE[7:3] && cmd[2:0] != 3'd0
               && !cfg_q[4][LOCK_BIT])
      begin
        for (int i = 1; i <= 7; i++)
          if (cmd[2:0] == 3'(i))
            cfg_q[i] <= arg;
        if (cmd[2:0] == 3'd2)
          cfg_q[2][MODE_BIT] <= 1'b0;
        if (cmd[2:0] == 3'd4)
          cfg_q[4][LOCK_BIT] <= cfg_q[4][LOCK_BIT];
      end
    end
  end

  // Fields driving the power stages
  assign pd1_short_thresh_sel   = cfg_q[1][THR_MSB:THR_LSB];
  assign pd1_short_filter_sel   = cfg_q[1][FLT_MSB:FLT_LSB];
  assign flywheel_full_adaptive = cfg_q[1][MODE_BIT];
  assign relay_overtemp_keep_on = cfg_q[1][CTRL_BIT];
  assign pd2_short_thresh_sel   = cfg_q[2][THR_MSB:THR_LSB];
  assign pd2_short_filter_sel   = cfg_q[2][FLT_MSB:FLT_LSB];
  assign ignition_lowside_force_off = cfg_q[2][CTRL_BIT];
  assign config_word_3 = cfg_q[3];
  assign config_word_4 = cfg_q[4];
  assign config_word_5 = cfg_q[5];
  assign config_word_6 = cfg_q[6];
  assign config_word_7 = cfg_q[7];
endmodule : sur_regmap
`default_nettype wire

// >>> sur_regmap_asserts.sv
// Checker of reset values and link timing of the register map
`default_nettype none
module sur_regmap_asserts
  import sur_pkg::*;
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       link_clk,
  input wire logic       link_en,
  input wire logic       link_sdo,
  input wire logic [2:0] pd1_short_thresh_sel,
  input wire logic [2:0] pd1_short_filter_sel,
  input wire logic [2:0] pd2_short_thresh_sel,
  input wire logic [2:0] pd2_short_filter_sel,
  input wire logic       flywheel_full_adaptive,
  input wire logic       relay_overtemp_keep_on,
  input wire logic       ignition_lowside_force_off,
  input wire logic [7:0] config_word_3,
  input wire logic [7:0] config_word_4,
  input wire logic [7:0] config_word_5,
  input wire logic [7:0] config_word_6,
  input wire logic [7:0] config_word_7
);
  logic [14:0] c12;
  logic [39:0] w37;
  assign c12 = {pd1_short_thresh_sel, pd1_short_filter_sel,
    flywheel_full_adaptive, relay_overtemp_keep_on, pd2_short_thresh_sel,
    pd2_short_filter_sel, ignition_lowside_force_off};
  assign w37 = {config_word_3, config_word_4, config_word_5, config_word_6,
    config_word_7};
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence en_busy; link_en [*6]; endsequence
  sequence shift_hold; (link_en && !link_clk) [*6]; endsequence
  sequence en_idle; !link_en [*8]; endsequence
  rst_cfg_a: assert property (
    $fell(sys_rst) |-> c12 == 15'h0404) else $error("cfg reset value");
  rst_words_a: assert property (
    $fell(sys_rst) |-> w37 == {CFG3_RST, CFG4_RST, CFG5_RST, CFG6_RST,
    CFG7_RST}) else $error("word reset value");
  cfg_quiet_a: assert property (en_busy |-> $stable(c12))
    else $error("cfg changed in frame");
  words_quiet_a: assert property (en_busy |-> $stable(w37))
    else $error("word changed in frame");
  cfg_late_a: assert property (
    $changed(c12) |-> !$past(link_en) && !$past(link_en, 2))
    else $error("cfg changed before frame end");
  words_late_a: assert property (
    $changed(w37) |-> !$past(link_en) && !$past(link_en, 2))
    else $error("word changed before frame end");
  sdo_hold_a: assert property (shift_hold |-> $stable(link_sdo))
    else $error("sdo moved without link clock rise");
  sdo_idle_a: assert property (en_idle |-> $stable(link_sdo))
    else $error("sdo moved between frames");
endmodule : sur_regmap_asserts
bind sur_regmap sur_regmap_asserts i_sur_regmap_asserts (
  .clock, .sys_rst, .link_clk, .link_en, .link_sdo, .pd1_short_thresh_sel,
  .pd1_short_filter_sel, .pd2_short_thresh_sel, .pd2_short_filter_sel,
  .flywheel_full_adaptive, .relay_overtemp_keep_on,
  .ignition_lowside_force_off, .config_word_3, .config_word_4,
  .config_word_5, .config_word_6, .config_word_7
);
`default_nettype wire

// >>> sur_master.sv
// Link master model that sends frames and collects upstream bits
`default_nettype none
module sur_master (
  output var logic link_clk,
  output var logic link_en,
  output var logic link_sdi,
  input  wire logic link_sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    link_clk = 1'b0;
    link_en  = 1'b0;
    link_sdi = 1'b0;
  end
  // Send n bits MSB first, clock standing still outside the frame
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'h0000;
    link_en = 1'b1;
    #62.5;
    for (int i = 15; i > 15 - n; i--)
    begin
      link_sdi = tx[i];
      #62.5;
      rx = {rx[14:0], link_sdo};
      link_clk = 1'b1;
      #62.5;
      link_clk = 1'b0;
    end
    #62.5;
    link_en = 1'b0;
    link_sdi = ~link_sdi;
    #100;
  endtask : frame
endmodule : sur_master
`default_nettype wire

// >>> tb_sur_regmap.sv
// Self-checking bench of the upstream register map
`default_nettype none
module tb_sur_regmap;
  timeunit 1ns;
  timeprecision 1ps;
  import sur_pkg::*;
  localparam logic [2:0] ID_CHIP  = 3'h5; // Arbitrary value
  localparam logic [2:0] ID_METAL = 3'h3; // Arbitrary value
  localparam logic [1:0] ID_MASK  = 2'h1; // Arbitrary value
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  wire logic  link_clk, link_en, link_sdi, link_sdo;
  logic [7:0] dw [1:12];
  logic [7:0] wq, wr, wt, wl, wh, wf, cw3, cw4, cw5, cw6, cw7;
  logic [9:0] st;
  logic       cpo, fly, rly, ignition_driver, lock;
  logic [2:0] p1t, p1f, p2t, p2f;
  logic [7:0] cfg [1:7];
  logic [1:0] mk;
  int         n_errors = 0;
  int         cmp_count = 0;
  always #4 clock = ~clock;
  sur_regmap #(.CHIP_ID(ID_CHIP), .METAL_REV(ID_METAL), .MASK_REV(ID_MASK))
  i_sur_regmap (
    .clock, .sys_rst, .link_clk, .link_en, .link_sdi, .link_sdo,
    .diag_word(dw), .watchdog_query(wq), .watchdog_reply(wr),
    .watchdog_reply_time(wt), .watchdog_request_low(wl),
    .watchdog_request_high(wh), .watchdog_fail_counter(wf),
    .step_total(st), .charge_pump_off(cpo), .pd1_short_thresh_sel(p1t),
    .pd1_short_filter_sel(p1f), .pd2_short_thresh_sel(p2t),
    .pd2_short_filter_sel(p2f), .flywheel_full_adaptive(fly),
    .relay_overtemp_keep_on(rly), .ignition_lowside_force_off(ignition_driver),
    .config_word_3(cw3), .config_word_4(cw4), .config_word_5(cw5),
    .config_word_6(cw6), .config_word_7(cw7)
  );
  sur_master i_sur_master (.link_clk, .link_en, .link_sdi, .link_sdo);
  function automatic logic [7:0] cfgrd(input int n);
    if (n == 2) return {cfg[2][7:2], cpo, cfg[2][0]};
    if (n == 4) return {cfg[4][7:1], lock};
    return cfg[n];
  endfunction : cfgrd
  function automatic logic [15:0] exp_slot(input int b, input int k);
    logic [7:0] d;
    logic [4:0] sh;
    logic [1:0] lo;
    lo = (b == 8) ? 2'h1 : (b >= 3 && b <= 5) ? 2'(b - 2) : 2'h0;
    sh = (k == 2) ? st[9:5] : st[4:0];
    case (b)
      1: d = cfgrd(k + 1);
      2: d = (k == 3) ? 8'h00 : cfgrd(k + 5);
      3, 4: d = dw[(b - 3) * 4 + k + 1];
      5: d = (k == 3) ? {ID_CHIP, ID_METAL, ID_MASK} : dw[9 + k];
      6: d = (k < 2) ? ((k == 0) ? wq : 8'h00) : {mk, 1'b0, sh};
      7: d = (k < 2) ? dw[12] : (k == 2) ? wr : wt;
      default: d = (k == 0) ? wt : (k == 1) ? wl : (k == 2) ? wh : wf;
    endcase
    return {2'(k), lo, d, 4'h0};
  endfunction : exp_slot
  task automatic chk(input string w, input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic chk8(input string w, input logic [7:0] g, input logic [7:0] e);
    chk(w, {8'h00, g}, {8'h00, e});
  endtask : chk8
  task automatic rnd_in();
    foreach (dw[i]) dw[i] = 8'($urandom);
    {wq, wr, wt, wl} = $urandom;
    {wh, wf, st, cpo} = 27'($urandom);
  endtask : rnd_in
  task automatic rd_blk(input int b);
    logic [15:0] rx;
    i_sur_master.frame({CMD_RD_BASE + 8'(b), 8'h00}, 16, rx);
    for (int k = 0; k < 4; k++)
    begin
      i_sur_master.frame(16'hff00, 16, rx);
      chk("slot", rx, exp_slot(b, k));
    end
    if (b == 6) mk++;
  endtask : rd_blk
  task automatic sr(input int b, input int k);
    logic [15:0] rx;
    logic [15:0] ef;
    ef = exp_slot(b, k);
    i_sur_master.frame({CMD_RD_ONE, 1'b0, 3'(b - 1), ef[15:12]}, 16, rx);
    i_sur_master.frame(16'hff00, 16, rx);
    chk("single", rx, exp_slot(b, k));
    if (b == 6) mk++;
  endtask : sr
  task automatic wr_cfg(input int n, input logic [7:0] v);
    logic [15:0] rx;
    i_sur_master.frame({CMD_WR_BASE + 8'(n), v}, 16, rx);
    if (!lock) cfg[n] = v;
  endtask : wr_cfg
  task automatic chk_out();
    chk8("cfg1", {p1t, p1f, fly, rly}, cfg[1]);
    chk8("cfg2", {p2t, p2f, 1'b0, ignition_driver}, cfg[2] & 8'hfd);
    chk8("cfg3", cw3, cfg[3]);
    chk8("cfg4", cw4 & 8'hfe, cfg[4] & 8'hfe);
    chk8("cfg5", cw5, cfg[5]);
    chk8("cfg6", cw6, cfg[6]);
    chk8("cfg7", cw7, cfg[7]);
  endtask : chk_out
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial
  begin
    #600_000;
    n_errors++;
    final_report();
  end
  initial
  begin
    logic [15:0] rx;
    void'($urandom(32'hb442));
    rnd_in();
    cfg = '{CFG1_RST, CFG2_RST, CFG3_RST, CFG4_RST, CFG5_RST, CFG6_RST,
            CFG7_RST};
    lock = 1'b0;
    mk = 2'h0;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    chk_out();
    for (int b = 1; b <= 2; b++) rd_blk(b);
    $display("Test reset values done");
    @(negedge clock);
    rnd_in();
    for (int n = 1; n <= 7; n++) wr_cfg(n, 8'($urandom));
    chk_out();
    wr_cfg(1, 8'hff);
    wr_cfg(2, 8'hff);
    chk_out();
    for (int b = 1; b <= 8; b++) rd_blk(b);
    $display("Test random map done");
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clock);
      st = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($urandom);
      rd_blk(6);
    end
    $display("Test step count done");
    i_sur_master.frame({CMD_LOCK, 8'h00}, 16, rx);
    lock = 1'b1;
    wr_cfg(1, ~cfg[1]);
    wr_cfg(5, ~cfg[5]);
    chk_out();
    rd_blk(1);
    i_sur_master.frame({CMD_UNLOCK, 8'h00}, 16, rx);
    lock = 1'b0;
    wr_cfg(1, 8'h5a);
    chk_out();
    i_sur_master.frame({CMD_WR_BASE + 8'h01, 8'hc3}, 15, rx);
    chk_out();
    $display("Test lock and short frame done");
    sr(1, 0);
    sr(7, 2);
    sr(6, 3);
    sr(5, 3);
    $display("Test single read done");
    final_report();
  end
endmodule : tb_sur_regmap
`default_nettype wire
